// [rscf_defs.svh]
// ============================================================
// constants of the reset cause flag and reset sequencer block
// ============================================================
// assumes: included by bare name; byte offsets on an 8-bit bus
`ifndef RSCF_DEFS_SVH
`define RSCF_DEFS_SVH

// ============================================================
// register byte offsets
// ============================================================
`define RSCF_OFF_FLAGS    8'h00
`define RSCF_OFF_PROT     8'h04
`define RSCF_OFF_BITOP    8'h08
`define RSCF_OFF_SETTLE   8'h0C
`define RSCF_OFF_DEBUG    8'h10
`define RSCF_OFF_STATUS   8'h14
`define RSCF_OFF_CPUCLK   8'h18

// ============================================================
// field positions and masks
// ============================================================
`define RSCF_BIT_WDT      4
`define RSCF_BIT_CLM      1
`define RSCF_BIT_LVD      0
`define RSCF_FLAGS_MASK   8'h13
`define RSCF_BITOP_VAL    7

// ============================================================
// reset values and keys
// ============================================================
`define RSCF_FLAGS_RST    8'h00
`define RSCF_DEBUG_RST    8'h01
`define RSCF_SETTLE_RST   3'h0
`define RSCF_CPU_DIV8     3'h3
`define RSCF_PROT_KEY     8'hA5

// ============================================================
// timing: main clock periods of oscillation settling
// ============================================================
`define RSCF_SETTLE_FX_CYC 65536
`define RSCF_CNT_W        17

`endif

// [rscf_pkg.sv]
// ============================================================
// types of the reset cause flag and reset sequencer block
// ============================================================
// assumes: compiled before every module of the block
package rscf_pkg;

  typedef enum logic [1:0] {
    RSCF_ST_RESET  = 2'b00,
    RSCF_ST_SETTLE = 2'b01,
    RSCF_ST_RUN    = 2'b10
  } rscf_state_t;

  // reset sources, all active high after synchronising
  typedef struct packed {
    logic pin;
    logic power_on_clear;
    logic wdt;
    logic clock_monitor;
    logic lvd;
  } rscf_src_t;

  typedef struct packed {
    logic       main_osc_en;
    logic       int_osc_en;
    logic       sub_rc_en;
    logic       sub_xtal_en;
    logic       periph_clk_en;
    logic       cpu_clk_en;
    logic [2:0] cpu_clk_sel;
  } rscf_clk_ctl_t;

endpackage : rscf_pkg

// [rscf_sync.sv]
// ============================================================
// two-flop synchroniser for the asynchronous reset sources
// ============================================================
// assumes: inputs come from pins or analog detectors
`timescale 1ns/10ps
module rscf_sync #(
  parameter int unsigned W = 5
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // first stage feeds only the second stage
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        meta_d[g] = i_rst_b ? i_async[g] : 1'b0;
        sync_d[g] = i_rst_b ? meta_q[g] : 1'b0;
      end
      always_ff @(posedge i_ref_clk) begin
        meta_q[g] <= meta_d[g];
        sync_q[g] <= sync_d[g];
      end
    end
  endgenerate

  assign o_sync = sync_q;

endmodule : rscf_sync

// [rscf_top.sv]
// ============================================================
// reset cause flags and reset sequencer
// ============================================================
// holds: reset cause flag register, protected write, system
//   reset state machine, oscillator settle count, clock and
//   port control during reset.
// assumes: one 20 MHz clock that stands in for the main clock;
//   reset sources arrive asynchronously; plain register port.
`timescale 1ns/10ps
`include "rscf_defs.svh"

// Functional notes
// - flag writes only after protect key
// - byte or single-bit flag access
// - pin or power-on clear zeroes flags
// - clock monitor reset sets bit one
// - low-voltage reset sets bit zero; others kept
// - source resets keep other flags
// - pin low holds system reset
// - pin rising releases reset
// - oscillators stop in reset, crystal continues
// - peripheral clocks wait for settle time
// - cpu clock restarts divided by eight
// - cpu runs only after settle time
// - watchdog cleared in reset, runs after
// - ports high impedance during reset
// - pin reset initialises, debug mode 01
// - settle 2^16 main clocks after reset
module rscf_top #(
  parameter int unsigned P_SETTLE_CYC = `RSCF_SETTLE_FX_CYC
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_reset_pin_b,
  input  wire logic              i_power_on_clear,
  input  wire logic              i_watchdog_timer_ovf,
  input  wire logic              i_clock_monitor_stop,
  input  wire logic              i_low_voltage_detect,
  input  wire logic [7:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  output logic                   o_sys_reset,
  output rscf_pkg::rscf_clk_ctl_t o_clk_ctl,
  output logic                   o_cpu_run,
  output logic                   o_wdt_clear,
  output logic                   o_wdt_run,
  output logic                   o_port_hiz,
  output logic                   o_periph_init,
  output logic      [7:0]        o_debug_mode
);

  // ============================================================
  // helpers
  // ============================================================
  function automatic logic hit(
    input logic [7:0] addr,
    input logic [7:0] off
  );
    hit = (addr == off);
  endfunction : hit

  // settle length for a select code, never below zero cycles
  function automatic logic [`RSCF_CNT_W-1:0] settle_load(
    input logic [2:0] sel
  );
    logic [`RSCF_CNT_W-1:0] len;
    len = `RSCF_CNT_W'(P_SETTLE_CYC >> sel);
    if (len == `RSCF_CNT_W'(0)) begin
      settle_load = `RSCF_CNT_W'(0);
    end else begin
      settle_load = len - `RSCF_CNT_W'(1);
    end
  endfunction : settle_load

  // state decode shared by register and control logic
  function automatic logic is_reset(
    input rscf_pkg::rscf_state_t st
  );
    is_reset = (st == rscf_pkg::RSCF_ST_RESET);
  endfunction : is_reset

  function automatic logic is_run(
    input rscf_pkg::rscf_state_t st
  );
    is_run = (st == rscf_pkg::RSCF_ST_RUN);
  endfunction : is_run

  // ============================================================
  // source synchronising
  // ============================================================
  logic [4:0]          src_raw;
  logic [4:0]          src_sync;
  rscf_pkg::rscf_src_t src;
  rscf_pkg::rscf_src_t src_prev_q;
  rscf_pkg::rscf_src_t src_prev_d;
  logic                any_src;

  assign src_raw = {i_reset_pin_b, i_power_on_clear,
                    i_watchdog_timer_ovf, i_clock_monitor_stop,
                    i_low_voltage_detect};

  // every source is asynchronous: two flops before any use
  rscf_sync #(
    .W (5)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_async   (src_raw),
    .o_sync    (src_sync)
  );

  always_comb begin
    src.pin = ~src_sync[4];
    src.power_on_clear = src_sync[3];
    src.wdt = src_sync[2];
    src.clock_monitor = src_sync[1];
    src.lvd = src_sync[0];
  end

  // any source drives the system reset
  assign any_src = src.pin | src.power_on_clear | src.wdt | src.clock_monitor | src.lvd;

  // last synced levels, zero after reset so no edge is faked
  always_comb begin
    src_prev_d = i_rst_b ? src : '0;
  end

  always_ff @(posedge i_ref_clk) begin
    src_prev_q <= src_prev_d;
  end

  // ============================================================
  // reset sequencer
  // ============================================================
  rscf_pkg::rscf_state_t  state_q;
  rscf_pkg::rscf_state_t  state_d;
  logic [`RSCF_CNT_W-1:0] cnt_q;
  logic [`RSCF_CNT_W-1:0] cnt_d;
  logic [2:0]             settle_sel_q;

  // limitation: settle select is reset in RESET, so each release
  // waits the default length
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (!i_rst_b) begin
      state_d = rscf_pkg::RSCF_ST_RESET;
      cnt_d   = `RSCF_CNT_W'(0);
    end else begin
      unique case (state_q)
        rscf_pkg::RSCF_ST_RESET: begin
          // leave reset once all sources drop
          if (!any_src) begin
            state_d = rscf_pkg::RSCF_ST_SETTLE;
            cnt_d   = settle_load(settle_sel_q);
          end
        end
        rscf_pkg::RSCF_ST_SETTLE: begin
          if (any_src) begin
            state_d = rscf_pkg::RSCF_ST_RESET;
          end else if (cnt_q == `RSCF_CNT_W'(0)) begin
            state_d = rscf_pkg::RSCF_ST_RUN;
          end else begin
            cnt_d = cnt_q - `RSCF_CNT_W'(1);
          end
        end
        rscf_pkg::RSCF_ST_RUN: begin
          if (any_src) begin
            state_d = rscf_pkg::RSCF_ST_RESET;
          end
        end
        default: begin
          state_d = rscf_pkg::RSCF_ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    state_q <= state_d;
    cnt_q   <= cnt_d;
  end

  // ============================================================
  // register writes
  // ============================================================
  // an armed key has no timeout; it waits for the next write
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic       prot_q;
  logic       prot_d;
  logic [2:0] settle_sel_d;
  logic [2:0] cpu_sel_q;
  logic [2:0] cpu_sel_d;
  logic [7:0] debug_q;
  logic [7:0] debug_d;
  logic       in_rst;
  logic [7:0] rise;

  assign in_rst = is_reset(state_q);

  // synced level edge: a held source sets its flag only once
  always_comb begin
    rise = 8'h00;
    rise[`RSCF_BIT_WDT] = src.wdt & ~src_prev_q.wdt;
    rise[`RSCF_BIT_CLM] = src.clock_monitor & ~src_prev_q.clock_monitor;
    rise[`RSCF_BIT_LVD] = src.lvd & ~src_prev_q.lvd;
  end

  always_comb begin
    flags_d = flags_q;
    // reads leave the key armed; any other write disarms it
    // key arms exactly the next write
    prot_d  = i_wr ? (hit(i_addr, `RSCF_OFF_PROT) &&
                      (i_wdata == `RSCF_PROT_KEY)) : prot_q;
    // whole-byte write needs the armed key
    if (i_wr && prot_q && hit(i_addr, `RSCF_OFF_FLAGS)) begin
      flags_d = i_wdata;
    end
    if (i_wr && prot_q && hit(i_addr, `RSCF_OFF_BITOP)) begin
      flags_d[i_wdata[2:0]] = i_wdata[`RSCF_BITOP_VAL];
    end
    flags_d = flags_d | rise;
    // pin or power-on clear zeroes all
    if (!i_rst_b || src.pin || src.power_on_clear) begin
      flags_d = `RSCF_FLAGS_RST;
    end
    flags_d = flags_d & `RSCF_FLAGS_MASK;
    if (!i_rst_b) begin
      prot_d = 1'b0;
    end
  end

  always_comb begin
    settle_sel_d = settle_sel_q;
    cpu_sel_d    = cpu_sel_q;
    debug_d      = debug_q;
    if (i_wr && hit(i_addr, `RSCF_OFF_SETTLE)) begin
      settle_sel_d = i_wdata[2:0];
    end
    if (i_wr && hit(i_addr, `RSCF_OFF_CPUCLK)) begin
      cpu_sel_d = i_wdata[2:0];
    end
    if (i_wr && hit(i_addr, `RSCF_OFF_DEBUG)) begin
      debug_d = i_wdata;
    end
    // cpu clock select back to divide by eight
    if (!i_rst_b || in_rst) begin
      settle_sel_d = `RSCF_SETTLE_RST;
      cpu_sel_d    = `RSCF_CPU_DIV8;
    end
    // other resets keep it, so a debug session survives them
    // debug mode set only by pin reset
    if (!i_rst_b || src.pin) begin
      debug_d = `RSCF_DEBUG_RST;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    flags_q      <= flags_d;
    prot_q       <= prot_d;
    settle_sel_q <= settle_sel_d;
    cpu_sel_q    <= cpu_sel_d;
    debug_q      <= debug_d;
  end

  // ============================================================
  // register reads
  // ============================================================
  logic [7:0] rdata_d;

  // read data only in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (i_rst_b && i_rd) begin
      unique case (i_addr)
        `RSCF_OFF_FLAGS:  rdata_d = flags_q;
        `RSCF_OFF_SETTLE: rdata_d = {5'h00, settle_sel_q};
        `RSCF_OFF_DEBUG:  rdata_d = debug_q;
        `RSCF_OFF_STATUS: rdata_d = {5'h00, prot_q, state_q};
        `RSCF_OFF_CPUCLK: rdata_d = {5'h00, cpu_sel_q};
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    o_rdata <= rdata_d;
  end

  // ============================================================
  // system controls, registered from the next state
  // ============================================================
  rscf_pkg::rscf_clk_ctl_t ctl_d;
  logic                    rst_d;
  logic                    run_d;

  // next-state decode, so the outputs move with state_q
  assign rst_d = is_reset(state_d);
  assign run_d = is_run(state_d);

  always_comb begin
    ctl_d.main_osc_en   = ~rst_d;
    ctl_d.int_osc_en    = ~rst_d;
    ctl_d.sub_rc_en     = ~rst_d;
    // crystal subclock is never stopped by reset
    ctl_d.sub_xtal_en   = 1'b1;
    ctl_d.periph_clk_en = run_d;
    // system and cpu clock after settling
    ctl_d.cpu_clk_en    = run_d;
    // software selection reaches the cpu clock only outside reset
    ctl_d.cpu_clk_sel   = rst_d ? `RSCF_CPU_DIV8 : cpu_sel_d;
  end

  always_ff @(posedge i_ref_clk) begin
    o_clk_ctl     <= ctl_d;
    // system reset while any source holds
    o_sys_reset   <= rst_d;
    o_cpu_run     <= run_d;
    o_wdt_clear   <= rst_d;
    o_wdt_run     <= ~rst_d;
    o_port_hiz    <= rst_d;
    o_periph_init <= rst_d;
    o_debug_mode  <= debug_d;
  end

endmodule : rscf_top

// [rscf_top_checker.sv]
// ==========================================================
// port assertions of the reset flag block
// ==========================================================
// assumes: bound to rscf_top; one clock, sync active-low reset
`timescale 1ns/10ps
module rscf_top_checker #(
  parameter int unsigned P_SETTLE_CYC = 16
) (
  input wire logic                    i_ref_clk,
  input wire logic                    i_rst_b,
  input wire logic                    i_reset_pin_b,
  input wire logic                    i_power_on_clear,
  input wire logic                    i_watchdog_timer_ovf,
  input wire logic                    i_clock_monitor_stop,
  input wire logic                    i_low_voltage_detect,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic                    o_sys_reset,
  input wire rscf_pkg::rscf_clk_ctl_t o_clk_ctl,
  input wire logic                    o_cpu_run,
  input wire logic                    o_wdt_clear,
  input wire logic                    o_wdt_run,
  input wire logic                    o_port_hiz,
  input wire logic                    o_periph_init
);
  logic        src_any;
  int unsigned settle_d;
  int unsigned settle_q;

  assign src_any = i_power_on_clear | i_watchdog_timer_ovf
                 | i_clock_monitor_stop | i_low_voltage_detect;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  // ==========================================================
  // cycles spent settling, held once the cpu runs
  // ==========================================================
  always_comb begin
    settle_d = settle_q + 1;
    if (o_sys_reset)
      settle_d = 0;
    else if (o_cpu_run)
      settle_d = settle_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b)
      settle_q <= 0;
    else
      settle_q <= settle_d;
  end

  // ==========================================================
  // assertions
  // ==========================================================
  hiz_in_reset_a: assert property (
    o_sys_reset |-> o_port_hiz && o_periph_init)
    else $error("ports not floated in reset");
  osc_stop_a: assert property (
    o_sys_reset |-> o_clk_ctl[8:6] == 3'h0 && o_clk_ctl.sub_xtal_en)
    else $error("oscillators wrong in reset");
  osc_restart_a: assert property (
    $fell(o_sys_reset) |-> o_clk_ctl[8:6] == 3'h7)
    else $error("oscillators not restarted");
  cpu_div8_a: assert property (
    o_sys_reset |-> o_clk_ctl.cpu_clk_sel == 3'h3 && o_clk_ctl[4:3] == 2'h0)
    else $error("cpu clock not stopped at divide by eight");
  wdt_ctl_a: assert property (
    o_wdt_run == !o_sys_reset && o_wdt_clear == o_sys_reset)
    else $error("watchdog control wrong");
  settle_len_a: assert property (
    $rose(o_cpu_run) |-> settle_q == P_SETTLE_CYC)
    else $error("settle time wrong");
  run_clk_a: assert property (
    o_clk_ctl[4:3] == {2{o_cpu_run}} && !(o_cpu_run && o_sys_reset))
    else $error("clocks and cpu run disagree");
  pin_hold_a: assert property (
    !i_reset_pin_b [*3] |=> o_sys_reset)
    else $error("pin low without system reset");
  release_a: assert property (
    (i_reset_pin_b && !src_any) [*4] |=> !o_sys_reset)
    else $error("reset not released");
  src_reset_a: assert property (
    src_any [*3] |=> o_sys_reset)
    else $error("source without system reset");
endmodule : rscf_top_checker

bind rscf_top rscf_top_checker #(.P_SETTLE_CYC(P_SETTLE_CYC)) i_chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reset_pin_b(i_reset_pin_b),
  .i_power_on_clear(i_power_on_clear), .i_wr(i_wr), .i_rd(i_rd),
  .i_watchdog_timer_ovf(i_watchdog_timer_ovf),
  .i_clock_monitor_stop(i_clock_monitor_stop),
  .i_low_voltage_detect(i_low_voltage_detect),
  .o_sys_reset(o_sys_reset), .o_clk_ctl(o_clk_ctl), .o_cpu_run(o_cpu_run),
  .o_wdt_clear(o_wdt_clear), .o_wdt_run(o_wdt_run),
  .o_port_hiz(o_port_hiz), .o_periph_init(o_periph_init)
);

// [rscf_rst_circ.sv]
// ==========================================================
// external reset supervisor driving the reset pin
// ==========================================================
// assumes: press request from the bench; pin pulled up at rest
`timescale 1ns/10ps
module rscf_rst_circ #(
  parameter int unsigned MIN_LOW = 6
) (
  input  wire logic i_ref_clk,
  input  wire logic i_press,
  output logic      o_reset_pin_b
);
  int unsigned low_q = 0;

  // stretched so the pin always outlasts the synchroniser
  always @(posedge i_ref_clk) begin
    if (i_press)
      low_q <= MIN_LOW;
    else if (low_q != 0)
      low_q <= low_q - 1;
  end

  assign o_reset_pin_b = (low_q == 0);
endmodule : rscf_rst_circ

// [tb.sv]
// ==========================================================
// self-checking bench of the reset flag block
// ==========================================================
// assumes: design, checker and supervisor model compiled first
`timescale 1ns/10ps
module tb;
  localparam int unsigned SETTLE = 16;
  logic                    ref_clk;
  logic                    rst_b;
  logic                    press;
  logic                    pin_b;
  logic                    power_on_clear;
  logic [2:0]              src;
  logic                    wr;
  logic                    rd;
  logic [7:0]              addr;
  logic [7:0]              wdata;
  logic [7:0]              rdata;
  logic [7:0]              dbg;
  logic                    sys_rst;
  logic                    cpu_run;
  wire  [3:0]              ctl;
  rscf_pkg::rscf_clk_ctl_t clk_ctl;
  int                      err_total = 0;
  int                      tests_run = 0;

  rscf_rst_circ i_circ (.i_ref_clk(ref_clk), .i_press(press),
    .o_reset_pin_b(pin_b));
  rscf_top #(.P_SETTLE_CYC(SETTLE)) i_dut (
    .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_reset_pin_b(pin_b),
    .i_power_on_clear(power_on_clear), .i_watchdog_timer_ovf(src[2]),
    .i_clock_monitor_stop(src[1]), .i_low_voltage_detect(src[0]),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_sys_reset(sys_rst), .o_clk_ctl(clk_ctl),
    .o_cpu_run(cpu_run), .o_wdt_clear(ctl[1]), .o_wdt_run(ctl[0]),
    .o_port_hiz(ctl[3]), .o_periph_init(ctl[2]), .o_debug_mode(dbg));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic chk(input string nm, input logic [8:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic wr8(input logic [7:0] a, d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr8

  task automatic rd8(input logic [7:0] a, exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {1'b0, rdata}, {1'b0, exp});
  endtask : rd8

  // counts settle cycles; call only while system reset stands
  task automatic wait_run;
    int n;
    n = 0;
    for (int i = 0; i < 400 && cpu_run !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
      if (sys_rst === 1'b0 && cpu_run !== 1'b1)
        n++;
    end
    if (cpu_run !== 1'b1) begin
      err_total++;
      test_done();
    end else begin
      chk("settle", 9'(n), 9'(SETTLE));
      chk("run clk", clk_ctl, 9'h1FB);
    end
  endtask : wait_run

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_sources;
    logic [7:0] exp;
    exp = 8'h00;
    for (int i = 2; i >= 0; i--) begin
      @(posedge ref_clk);
      src[i] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      chk("sys reset", {8'h00, sys_rst}, 9'h001);
      chk("reset clk", clk_ctl, 9'h023);
      chk("reset ctl", {5'h00, ctl}, 9'h00E);
      @(posedge ref_clk);
      src[i] <= 1'b0;
      exp = exp | ((i == 2) ? 8'h10 : (8'h01 << i));
      wait_run();
      rd8(8'h00, exp);
    end
  endtask : t_sources

  task automatic t_protect;
    wr8(8'h00, 8'h00);
    rd8(8'h00, 8'h13);
    wr8(8'h04, 8'hA5);
    wr8(8'h10, 8'h00);
    wr8(8'h00, 8'h00);
    rd8(8'h00, 8'h13);
    wr8(8'h04, 8'hA5);
    rd8(8'h14, 8'h06);
    wr8(8'h08, 8'h04);
    rd8(8'h00, 8'h03);
    rd8(8'h14, 8'h02);
    wr8(8'h04, 8'hA5);
    wr8(8'h00, 8'hFF);
    rd8(8'h00, 8'h13);
    wr8(8'h18, 8'h05);
    rd8(8'h18, 8'h05);
    chk("cpu sel", {6'h00, clk_ctl.cpu_clk_sel}, 9'h005);
    wr8(8'h0C, 8'h02);
    rd8(8'h0C, 8'h02);
  endtask : t_protect

  task automatic t_pin;
    @(posedge ref_clk);
    press <= 1'b1;
    @(posedge ref_clk);
    press <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("pin reset", {8'h00, sys_rst}, 9'h001);
    chk("debug", {1'b0, dbg}, 9'h001);
    wait_run();
    rd8(8'h00, 8'h00);
    rd8(8'h0C, 8'h00);
    rd8(8'h18, 8'h03);
  endtask : t_pin

  task automatic t_poc;
    wr8(8'h04, 8'hA5);
    wr8(8'h00, 8'h11);
    rd8(8'h00, 8'h11);
    @(posedge ref_clk);
    power_on_clear <= 1'b1;
    repeat (4) @(posedge ref_clk);
    power_on_clear <= 1'b0;
    wait_run();
    rd8(8'h00, 8'h00);
  endtask : t_poc

  initial begin
    rst_b = 1'b0;
    press = 1'b0;
    power_on_clear = 1'b0;
    src = 3'h0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (20) @(posedge ref_clk);
    chk("init ctl", {4'h0, sys_rst, ctl}, 9'h01E);
    chk("init clk", clk_ctl, 9'h023);
    rst_b <= 1'b1;
    wait_run();
    rd8(8'h00, 8'h00);
    rd8(8'h10, 8'h01);
    t_sources();
    t_protect();
    t_pin();
    t_poc();
    test_done();
  end
endmodule : tb
